// ==== hdl/cpsc_ctrl.v ====
// cpsc_ctrl.v: clock prescale, sleep and peripheral clock gating control
// assumes the cpu presents register writes as one-cycle strobes on clk
`timescale 1ns/1ps
`include "cpsc_defs.vh"
module cpsc_ctrl (
  // clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // fuse, strap level from outside
  input  wire       divide_by_eight_fuse,
  // prescale register write port
  input  wire       clock_prescale_wr,
  input  wire [7:0] clock_prescale_wdata,
  output wire [7:0] clock_prescale_rdata,
  // mcu control register write port
  input  wire       mcu_control_wr,
  input  wire [7:0] mcu_control_wdata,
  output wire [7:0] mcu_control_rdata,
  // power reduction register write port
  input  wire       power_reduction_wr,
  input  wire [7:0] power_reduction_wdata,
  output wire [7:0] power_reduction_rdata,
  // cpu status and wake sources
  input  wire       halt_exec,
  input  wire       irq_pending,
  input  wire       conv_done_irq,
  input  wire       nvm_ready_irq,
  input  wire       ext_irq_zero_level,
  input  wire       pin_change_irq,
  input  wire       crystal_selected,
  input  wire       conv_enabled,
  // clock enables and control outputs
  output wire       cpu_clock_domain_en,
  output wire       flash_clock_domain_en,
  output wire       io_clock_domain_en,
  output wire       conv_clock_en,
  output wire       osc_enable,
  output wire       timer1_clk_en,
  output wire       timer0_clk_en,
  output wire       serial_unit_clk_en,
  output wire       converter_clk_en,
  output wire [3:0] periph_access_block,
  output reg        conv_start,
  output reg        sleeping
);
  localparam ST_ACTIVE = 2'h0;
  localparam ST_SLEEP  = 2'h1;
  localparam ST_WAKE   = 2'h2;

  reg  [3:0] clock_divide_select_r;
  reg  [2:0] unlock_cnt_r;
  reg        prescale_change_unlock_r;
  reg        sleep_arm_r;
  reg  [1:0] sleep_mode_select_r;
  reg  [3:0] power_reduction_r;
  reg  [1:0] state_r;
  reg  [1:0] act_mode_r;
  reg  [3:0] wake_cnt_r;
  reg        fuse_s1_r;
  reg        fuse_s2_r;
  reg        fuse_v1_r;
  reg        fuse_v2_r;
  reg        crystal_s1_r;
  reg        crystal_s2_r;
  reg        fuse_done_r;
  wire       div_en;
  reg        wake_src;

  // deep modes have the oscillator-derived clocks stopped
  function deep_mode;
    input [1:0] mode;
    begin
      deep_mode = mode[1];
    end
  endfunction

  // standby needs a crystal; without one fall back to power-down
  function [1:0] entry_mode;
    input [1:0] mode;
    input       xtal;
    begin
      if (mode == `CPSC_MODE_STBY && !xtal)
        entry_mode = `CPSC_MODE_PDOWN;
      else
        entry_mode = mode;
    end
  endfunction

  // two flops on each strap before use
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fuse_s1_r    <= 1'b0;
      fuse_s2_r    <= 1'b0;
      fuse_v1_r    <= 1'b0;
      fuse_v2_r    <= 1'b0;
      crystal_s1_r <= 1'b0;
      crystal_s2_r <= 1'b0;
    end else begin
      fuse_s1_r    <= divide_by_eight_fuse;
      fuse_s2_r    <= fuse_s1_r;
      // marks the fuse synchroniser as filled
      fuse_v1_r    <= 1'b1;
      fuse_v2_r    <= fuse_v1_r;
      crystal_s1_r <= crystal_selected;
      crystal_s2_r <= crystal_s1_r;
    end
  end

  // prescale register and unlock window
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clock_divide_select_r    <= `CPSC_SEL_RESET;
      prescale_change_unlock_r <= 1'b0;
      unlock_cnt_r             <= 3'h0;
      fuse_done_r              <= 1'b0;
    end else if (!fuse_done_r) begin
      // fuse picks reset select
      // wait for the synchroniser, else a programmed fuse reads 0
      if (fuse_v2_r) begin
        fuse_done_r           <= 1'b1;
        clock_divide_select_r <= fuse_s2_r ? `CPSC_SEL_RESET_DIV8
                                           : `CPSC_SEL_RESET;
      end
    end else begin
      if (prescale_change_unlock_r) begin
        // timeout not extended
        // rewrites while open leave the count alone
        if (unlock_cnt_r == `CPSC_UNLOCK_CYCLES - 3'h1)
          prescale_change_unlock_r <= 1'b0;
        unlock_cnt_r <= unlock_cnt_r + 3'h1;
      end
      if (clock_prescale_wr) begin
        if (clock_prescale_wdata == 8'h80) begin
          if (!prescale_change_unlock_r) begin
            prescale_change_unlock_r <= 1'b1;
            unlock_cnt_r             <= 3'h0;
          end
        end else if (!clock_prescale_wdata[`CPSC_UNLOCK_BIT] &&
                     prescale_change_unlock_r) begin
          clock_divide_select_r    <= clock_prescale_wdata[3:0];
          prescale_change_unlock_r <= 1'b0;
        end
      end
    end
  end

  // reserved codes clamp to 256
  // slowest rate is the safe reading of a reserved code
  wire [3:0] eff_sel = (clock_divide_select_r > `CPSC_SEL_MAX) ?
                       `CPSC_SEL_MAX : clock_divide_select_r;

  cpsc_divider u_div (
    .clk     (clk),
    .reset_n (reset_n),
    .div_sel (eff_sel),
    .div_en  (div_en)
  );

  assign clock_prescale_rdata = {prescale_change_unlock_r, 3'h0,
                                 clock_divide_select_r};

  // mcu control and power reduction registers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_arm_r         <= 1'b0;
      sleep_mode_select_r <= 2'h0;
      power_reduction_r   <= 4'h0;
    end else begin
      if (mcu_control_wr) begin
        sleep_arm_r         <= mcu_control_wdata[5];
        sleep_mode_select_r <= mcu_control_wdata[4:3];
      end
      if (power_reduction_wr)
        power_reduction_r <= power_reduction_wdata[3:0];
    end
  end
  assign mcu_control_rdata = {2'h0, sleep_arm_r, sleep_mode_select_r,
                              3'h0};
  assign power_reduction_rdata = {4'h0, power_reduction_r};

  always @* begin
    case (act_mode_r)
      `CPSC_MODE_IDLE:  wake_src = irq_pending;
      `CPSC_MODE_NOISE: wake_src = conv_done_irq | nvm_ready_irq |
                                   ext_irq_zero_level | pin_change_irq;
      default:          wake_src = ext_irq_zero_level | pin_change_irq;
    endcase
  end

  // sleep sequencer
  // memories kept, only clocks stop
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // reset leaves sleep to reset vector
      state_r    <= ST_ACTIVE;
      act_mode_r <= 2'h0;
      wake_cnt_r <= 4'h0;
      conv_start <= 1'b0;
      sleeping   <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      case (state_r)
        ST_ACTIVE: begin
          if (halt_exec && sleep_arm_r && div_en) begin
            state_r    <= ST_SLEEP;
            sleeping   <= 1'b1;
            act_mode_r <= entry_mode(sleep_mode_select_r, crystal_s2_r);
            conv_start <= conv_enabled && !deep_mode(sleep_mode_select_r);
          end
        end
        ST_SLEEP: begin
          if (wake_src) begin
            state_r <= ST_WAKE;
            wake_cnt_r <= (act_mode_r == `CPSC_MODE_STBY) ?
                          `CPSC_STBY_WAKE + `CPSC_WAKE_HALT - 4'h1 :
                          `CPSC_WAKE_HALT - 4'h1;
          end
        end
        ST_WAKE: begin
          if (wake_cnt_r == 4'h0) begin
            state_r  <= ST_ACTIVE;
            sleeping <= 1'b0;
          end else
            wake_cnt_r <= wake_cnt_r - 4'h1;
        end
        default: begin
          state_r  <= ST_ACTIVE;
          sleeping <= 1'b0;
        end
      endcase
    end
  end

  wire in_sleep = (state_r != ST_ACTIVE);
  // osc runs again while counting back in power-down wake
  wire osc_on = !in_sleep || !deep_mode(act_mode_r) ||
                act_mode_r == `CPSC_MODE_STBY || state_r == ST_WAKE;
  assign cpu_clock_domain_en   = div_en && !in_sleep;
  assign flash_clock_domain_en = div_en && !in_sleep;
  assign io_clock_domain_en = div_en && (!in_sleep ||
                               act_mode_r == `CPSC_MODE_IDLE);
  assign conv_clock_en = div_en && (!in_sleep || !deep_mode(act_mode_r));
  assign osc_enable    = osc_on;

  // gating applies on top of io clock, converter gate on top of conv clock
  genvar g;
  wire [3:0] pclk_en;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_gate
      wire dom = (g == `CPSC_GATE_CONV) ? conv_clock_en
                                        : io_clock_domain_en;
      assign pclk_en[g] = dom && !power_reduction_r[g];
    end
  endgenerate
  assign timer1_clk_en       = pclk_en[`CPSC_GATE_TIM1];
  assign timer0_clk_en       = pclk_en[`CPSC_GATE_TIM0];
  assign serial_unit_clk_en  = pclk_en[`CPSC_GATE_USI];
  assign converter_clk_en    = pclk_en[`CPSC_GATE_CONV];
  assign periph_access_block = power_reduction_r;
endmodule

// ==== hdl/cpsc_defs.vh ====
// cpsc_defs.vh: constants of the clock prescale and sleep controller
// assumes inclusion by bare name from each design file
`ifndef CPSC_DEFS_VH
`define CPSC_DEFS_VH
`define CPSC_UNLOCK_BIT      7
`define CPSC_SEL_W           4
`define CPSC_SEL_RESET       4'h0
`define CPSC_SEL_RESET_DIV8  4'h3
`define CPSC_SEL_MAX         4'h8
`define CPSC_UNLOCK_CYCLES   3'h4
`define CPSC_WAKE_HALT       4'h4
`define CPSC_STBY_WAKE       4'h6
`define CPSC_MODE_IDLE       2'h0
`define CPSC_MODE_NOISE      2'h1
`define CPSC_MODE_PDOWN      2'h2
`define CPSC_MODE_STBY       2'h3
`define CPSC_GATE_TIM1       3
`define CPSC_GATE_TIM0       2
`define CPSC_GATE_USI        1
`define CPSC_GATE_CONV       0
`endif

// ==== hdl/cpsc_divider.v ====
// cpsc_divider.v: glitch-free power-of-two clock enable generator
// assumes one master clock; select changes are applied at period ends
`timescale 1ns/1ps
`include "cpsc_defs.vh"
module cpsc_divider (
  // clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // division select, already validated
  input  wire [3:0] div_sel,
  // one-cycle enable at the divided rate
  output reg        div_en
);
  reg [7:0] cnt_r;
  reg [3:0] cur_sel_r;
  wire [7:0] last_w;
  assign last_w = (8'h01 << cur_sel_r) - 8'h01;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r     <= 8'h00;
      cur_sel_r <= 4'h0;
      div_en    <= 1'b0;
    end else begin
      if (cnt_r == last_w || cur_sel_r == 4'h8 && cnt_r == 8'hFF) begin
        cnt_r     <= 8'h00;
        cur_sel_r <= div_sel;
        div_en    <= 1'b1;
      end else begin
        cnt_r  <= cnt_r + 8'h01;
        div_en <= 1'b0;
      end
    end
  end
endmodule

// ==== tb/cpsc_cpu_model.sv ====
// cpu side model: raises halt and holds it until sleep is taken
// assumes the bench lowers want_halt once sleeping is seen
`timescale 1ns/1ps
module cpsc_cpu_model (
  // clock and reset
  input  wire clk,
  input  wire reset_n,
  // bench request, block status
  input  wire want_halt,
  input  wire sleeping,
  output reg  halt_exec
);
  always @(negedge clk or negedge reset_n) begin
    if (!reset_n) halt_exec <= 1'b0;
    else halt_exec <= want_halt && !sleeping;
  end
endmodule

// ==== tb/cpsc_props_properties.sv ====
// checker: port-level relations of the prescale and sleep controller
// assumes bind onto cpsc_ctrl, one clock domain
`timescale 1ns/1ps
module cpsc_props (
  // clock and reset
  input wire       clk,
  input wire       reset_n,
  // register ports
  input wire       clock_prescale_wr,
  input wire [7:0] clock_prescale_wdata,
  input wire [7:0] clock_prescale_rdata,
  input wire [7:0] mcu_control_rdata,
  input wire       power_reduction_wr,
  input wire [7:0] power_reduction_wdata,
  input wire [7:0] power_reduction_rdata,
  // status and enables
  input wire       halt_exec,
  input wire       irq_pending,
  input wire       cpu_clock_domain_en,
  input wire       io_clock_domain_en,
  input wire       osc_enable,
  input wire       timer0_clk_en,
  input wire [3:0] periph_access_block,
  input wire       sleeping
);
  wire [7:0] pr = clock_prescale_rdata;
  wire [1:0] md = mcu_control_rdata[4:3];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_unlock_open;
    clock_prescale_wr && clock_prescale_wdata == 8'h80 && !pr[7];
  endsequence
  sequence s_halted_four;
    sleeping [*4];
  endsequence
  a_unlock_self_clear: assert property (s_unlock_open |=>
    pr[7] ##[1:4] !pr[7]) else $error("unlock window length wrong");
  a_select_taken: assert property (clock_prescale_wr &&
    !clock_prescale_wdata[7] && pr[7] |=> pr == {4'h0,
    $past(clock_prescale_wdata[3:0])}) else $error("select write lost");
  a_select_locked: assert property (clock_prescale_wr && !pr[7] &&
    clock_prescale_wdata != 8'h80 |=> $stable(pr))
    else $error("locked write changed prescale");
  a_sleep_armed: assert property ($rose(sleeping) |->
    $past(halt_exec) && $past(mcu_control_rdata[5]))
    else $error("sleep without halt and arm");
  a_idle_cpu_off: assert property (sleeping && md == 2'h0
    |-> !cpu_clock_domain_en) else $error("cpu clock runs in idle");
  a_noise_io_off: assert property (sleeping && md == 2'h1
    |-> !io_clock_domain_en) else $error("io clock runs in noise mode");
  a_pdown_osc_off: assert property ($rose(sleeping) && md == 2'h2
    |-> ##[0:1] !osc_enable) else $error("oscillator on in power-down");
  a_gate_write: assert property (power_reduction_wr |=>
    power_reduction_rdata == {4'h0, $past(power_reduction_wdata[3:0])}
    && periph_access_block == power_reduction_rdata[3:0])
    else $error("gate register mismatch");
  a_gate_blocks: assert property (periph_access_block[2]
    |-> !timer0_clk_en) else $error("gated timer clock pulsed");
  a_wake_halted: assert property ($rose(irq_pending) && sleeping &&
    md == 2'h0 |-> s_halted_four ##[1:3] !sleeping)
    else $error("idle wake timing wrong");
endmodule
bind cpsc_ctrl cpsc_props cpsc_props_inst (.clk, .reset_n,
  .clock_prescale_wr, .clock_prescale_wdata, .clock_prescale_rdata,
  .mcu_control_rdata, .power_reduction_wr, .power_reduction_wdata,
  .power_reduction_rdata, .halt_exec, .irq_pending, .cpu_clock_domain_en,
  .io_clock_domain_en, .osc_enable, .timer0_clk_en, .periph_access_block,
  .sleeping);

// ==== tb/tb.sv ====
// bench: prescale, gating and sleep scenarios through plain port writes
// assumes cpsc_ctrl and the cpu model; inputs move at falling edges
`timescale 1ns/1ps
module tb;
  reg clk, reset_n, divide_by_eight_fuse, want_halt;
  reg clock_prescale_wr, mcu_control_wr, power_reduction_wr;
  reg [7:0] clock_prescale_wdata, mcu_control_wdata, power_reduction_wdata;
  reg irq_pending, conv_done_irq, nvm_ready_irq, ext_irq_zero_level;
  reg pin_change_irq, crystal_selected, conv_enabled;
  wire [7:0] clock_prescale_rdata, mcu_control_rdata, power_reduction_rdata;
  wire cpu_clock_domain_en, flash_clock_domain_en, io_clock_domain_en;
  wire conv_clock_en, osc_enable, timer1_clk_en, timer0_clk_en;
  wire serial_unit_clk_en, converter_clk_en, conv_start, sleeping, halt_exec;
  wire [3:0] periph_access_block;
  wire [3:0] gv = {timer1_clk_en, timer0_clk_en, serial_unit_clk_en,
                   converter_clk_en};
  wire [3:0] sv = {cpu_clock_domain_en, io_clock_domain_en, conv_clock_en,
                   osc_enable};
  integer err_total, checks_done, c, m, k, g, n0;
  integer nst = 0;
  integer cycles = 0;
  reg [3:0] s;
  cpsc_ctrl cpsc_ctrl_inst (.*);
  cpsc_cpu_model cpsc_cpu_model_inst (.clk(clk), .reset_n(reset_n),
    .want_halt(want_halt), .sleeping(sleeping), .halt_exec(halt_exec));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(negedge clk) if (conv_start === 1'b1) nst = nst + 1;
  // hang guard, well above the longest run
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      err_total = err_total + 1;
      end_of_test;
    end
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // one-cycle write strobe: 0 prescale, 1 mcu control, 2 gates
  task wr(input integer r, input [7:0] d);
    begin
      @(negedge clk);
      clock_prescale_wdata = d;
      mcu_control_wdata = d;
      power_reduction_wdata = d;
      clock_prescale_wr = (r == 0);
      mcu_control_wr = (r == 1);
      power_reduction_wr = (r == 2);
      @(negedge clk);
      {clock_prescale_wr, mcu_control_wr, power_reduction_wr} = 3'h0;
    end
  endtask
  task rst(input f);
    begin
      reset_n = 1'b0;
      divide_by_eight_fuse = f;
      cyc(12);
      reset_n = 1'b1;
      cyc(4);
    end
  endtask
  // or of enables over 8 cycles
  task acc(input b);
    begin
      s = 4'h0;
      repeat (8) begin
        @(negedge clk);
        s = s | (b ? sv : gv);
      end
    end
  endtask
  task gap;
    begin
      @(negedge clk);
      while (!cpu_clock_domain_en) @(negedge clk);
      @(negedge clk);
      g = 1;
      while (!cpu_clock_domain_en) begin
        @(negedge clk);
        g = g + 1;
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks_done=%0d err_total=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    err_total = 0;
    checks_done = 0;
    {clock_prescale_wr, mcu_control_wr, power_reduction_wr} = 3'h0;
    {clock_prescale_wdata, mcu_control_wdata, power_reduction_wdata} = 0;
    {irq_pending, conv_done_irq, nvm_ready_irq, ext_irq_zero_level} = 4'h0;
    {pin_change_irq, want_halt} = 2'h0;
    {crystal_selected, conv_enabled} = 2'h3;
    rst(1'b1);
    chk(clock_prescale_rdata, 8'h03);
    wr(0, 8'h01);
    chk(clock_prescale_rdata, 8'h03);
    wr(0, 8'h81);
    chk(clock_prescale_rdata, 8'h03);
    wr(0, 8'h80);
    chk(clock_prescale_rdata, 8'h83);
    wr(0, 8'h80);
    cyc(2);
    chk(clock_prescale_rdata, 8'h03);
    wr(0, 8'h02);
    chk(clock_prescale_rdata, 8'h03);
    for (c = 0; c < 10; c = c + 1) begin
      wr(0, 8'h80);
      wr(0, c[7:0]);
      chk(clock_prescale_rdata, c[7:0]);
      gap;
      gap;
      chk(g, (c > 8) ? 16'h100 : 16'h1 << c);
    end
    wr(0, 8'h80);
    wr(0, 8'h00);
    gap;
    chk(g, 16'h1);
    conv_enabled = 1'b0;
    wr(2, 8'hF5);
    chk(power_reduction_rdata, 8'h05);
    acc(1'b0);
    chk(s, 4'hA);
    wr(2, 8'h00);
    conv_enabled = 1'b1;
    acc(1'b0);
    chk(s, 4'hF);
    wr(1, 8'h00);
    want_halt = 1'b1;
    cyc(20);
    chk(sleeping, 1'b0);
    want_halt = 1'b0;
    for (m = 0; m < 4; m = m + 1) begin
      wr(1, 8'h20 | (m[7:0] << 3));
      n0 = nst;
      want_halt = 1'b1;
      k = 0;
      while (sleeping !== 1'b1 && k < 600) begin
        @(negedge clk);
        k = k + 1;
      end
      want_halt = 1'b0;
      acc(1'b1);
      chk(s, (16'h1037 >> (4 * m)) & 16'hF);
      chk(nst - n0, m < 2);
      if (m > 0) begin
        irq_pending = 1'b1;
        cyc(10);
        chk(sleeping, 1'b1);
        irq_pending = 1'b0;
      end
      {pin_change_irq, ext_irq_zero_level, conv_done_irq, irq_pending} =
        4'h1 << m;
      k = 0;
      while (sleeping === 1'b1 && k < 40) begin
        @(negedge clk);
        k = k + 1;
      end
      chk(k >= (m == 3 ? 10 : 4) && k <= (m == 3 ? 12 : 6), 1);
      {pin_change_irq, ext_irq_zero_level, conv_done_irq, irq_pending} = 0;
      cyc(2);
    end
    wr(1, 8'h30);
    want_halt = 1'b1;
    cyc(20);
    want_halt = 1'b0;
    rst(1'b0);
    chk(sleeping, 1'b0);
    chk(clock_prescale_rdata, 8'h00);
    end_of_test;
  end
endmodule
